// >>> design/system_io_port_controller.sv
/*
 * System I/O port decoder: CPU reset, interval timer, diagnostic switches
 * and lamps, memory bank switching, sync test strobe and a DMA controller
 * with a four-channel register file, of which only channels 0 to 2 can request.
 * Assumes the processor I/O strobes, address and memory address come from
 * logic on clock_in; only the DIP switches come from outside.
 */
module system_io_port_controller #(
	parameter int unsigned TIMER_PERIOD_P = sysio_pkg::TIMER_PERIOD_CYCLES
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire logic [7:0] io_addr_in,
	input wire logic [7:0] io_data_in,
	input wire logic io_read_strobe_n_in,
	input wire logic io_write_strobe_n_in,
	output logic [7:0] io_data_out,
	output logic io_data_oe_out,
	input wire logic [14:0] cpu_mem_addr_in,
	input wire logic [5:0] diag_switch_in,
	input wire logic timer_irq_ack_in,
	input wire logic [2:0] dma_req_in,
	input wire logic hold_ack_in,
	output logic cpu_reset_n_out,
	output logic timer_irq_out,
	output logic switch_read_strobe_n_out,
	output logic lamp_latch_strobe_n_out,
	output logic [sysio_pkg::LAMP_W-1:0] lamp_out,
	output logic bank_strobe_n_out,
	output logic extended_addr_bit15_out,
	output logic extended_addr_bit14_out,
	output logic program_memory_select_out,
	output logic map_protect_enable_out,
	output logic sync_test_strobe_n_out,
	output logic dma_chip_select_n_out,
	output logic hold_request_out,
	output logic [sysio_pkg::NUM_CHAN-1:0] dma_ack_out,
	output logic dma_cycle_out,
	output logic [7:0] dma_addr_low_out,
	output logic [7:0] dma_addr_high_out,
	output logic [1:0] dma_cycle_type_out,
	output logic terminal_count_out
);
	import sysio_pkg::*;

	// ----------
	// Decoding helpers
	// ----------
	function automatic logic dma_hit(input logic [7:0] a);
		return a[7:4] == DMA_PORT_HIGH;
	endfunction

	function automatic logic dma_general(input logic [7:0] a);
		return dma_hit(a) && a[DMA_GROUP_BIT] &&
			(a[2:0] == DMA_GENERAL_SEL);
	endfunction

	function automatic logic dma_channel(input logic [7:0] a);
		return dma_hit(a) && !a[DMA_GROUP_BIT];
	endfunction

	function automatic logic [1:0] lowest(input logic [3:0] r);
		logic [1:0] c;
		c = 2'h3;
		for (int i = NUM_CHAN - 1; i >= 0; i--) begin
			if (r[i]) begin
				c = 2'(i);
			end
		end
		return c;
	endfunction

	// ----------
	// Declarations
	// ----------
	dma_mem_if mem_bus ();

	logic rd_n_prev_reg;
	logic wr_n_prev_reg;
	logic [7:0] acc_addr_reg;
	logic [5:0] switch_meta_reg;
	logic [5:0] switch_sync_reg;
	logic [2:0] reset_hold_reg;
	logic timer_en_reg;
	logic [TIMER_CNT_W-1:0] timer_cnt_reg;
	logic timer_tick;
	logic [3:0] bank_reg;
	logic byte_ptr_reg;
	logic [7:0] mode_reg;
	logic [3:0] tc_status_reg;
	logic [3:0] tc_set;
	logic [3:0] dma_req_all;
	dma_state_t dma_state_reg;
	logic [1:0] chan_reg;
	logic [15:0] addr_reg;
	logic [15:0] cnt_reg;

	logic rd_active;
	logic wr_active;
	logic rd_start;
	logic rd_end;
	logic wr_start;
	logic wr_end;
	logic status_read_end;

	assign rd_active = !io_read_strobe_n_in;
	assign wr_active = !io_write_strobe_n_in;
	assign rd_start = rd_active && rd_n_prev_reg;
	assign wr_start = wr_active && wr_n_prev_reg;
	assign rd_end = !rd_active && !rd_n_prev_reg;
	assign wr_end = !wr_active && !wr_n_prev_reg;
	assign status_read_end = rd_end && dma_general(acc_addr_reg);

	// Channel 3 has no requester; its request is held inactive.
	assign dma_req_all = {1'b0, dma_req_in} & mode_reg[3:0];

	// ----------
	// Strobe edges and switch synchroniser
	// ----------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rd_n_prev_reg <= 1'b1;
			wr_n_prev_reg <= 1'b1;
			acc_addr_reg <= 8'h00;
		end else if (clk_en_in) begin
			rd_n_prev_reg <= io_read_strobe_n_in;
			wr_n_prev_reg <= io_write_strobe_n_in;
			if (rd_start || wr_start) begin
				acc_addr_reg <= io_addr_in;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			switch_meta_reg <= 6'h00;
			switch_sync_reg <= 6'h00;
		end else if (clk_en_in) begin
			switch_meta_reg <= diag_switch_in;
			switch_sync_reg <= switch_meta_reg;
		end
	end

	// ----------
	// CPU reset
	// ----------
	// The reset flip-flop releases itself after a short hold so the
	// processor restarts without a separate set path.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cpu_reset_n_out <= 1'b1;
			reset_hold_reg <= 3'h0;
		end else if (clk_en_in) begin
			if (rd_start && io_addr_in == PORT_TIMER_RESET) begin
				cpu_reset_n_out <= 1'b0;
				reset_hold_reg <= CPU_RESET_HOLD_CYCLES - 3'h1;
			end else if (!cpu_reset_n_out) begin
				if (reset_hold_reg == 3'h0) begin
					cpu_reset_n_out <= 1'b1;
				end else begin
					reset_hold_reg <= reset_hold_reg - 3'h1;
				end
			end
		end
	end

	// ----------
	// Interval timer
	// ----------
	assign timer_tick = timer_en_reg &&
		(timer_cnt_reg == TIMER_CNT_W'(TIMER_PERIOD_P - 1));

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			timer_en_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (wr_start && io_addr_in == PORT_TIMER_RESET) begin
				timer_en_reg <= io_data_in[TIMER_EN_BIT];
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			timer_cnt_reg <= '0;
		end else if (clk_en_in) begin
			if (!timer_en_reg || timer_tick) begin
				timer_cnt_reg <= '0;
			end else begin
				timer_cnt_reg <= timer_cnt_reg + TIMER_CNT_W'(1);
			end
		end
	end

	// A tick in the same cycle as an acknowledge still leaves the
	// request pending, so no period is lost.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			timer_irq_out <= 1'b0;
		end else if (clk_en_in) begin
			if (timer_tick) begin
				timer_irq_out <= 1'b1;
			end else if (timer_irq_ack_in ||
				(wr_start && io_addr_in == PORT_TIMER_RESET &&
				!io_data_in[TIMER_EN_BIT])) begin
				timer_irq_out <= 1'b0;
			end
		end
	end

	// ----------
	// Port strobes and latches
	// ----------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			switch_read_strobe_n_out <= 1'b1;
			lamp_latch_strobe_n_out <= 1'b1;
			bank_strobe_n_out <= 1'b1;
			sync_test_strobe_n_out <= 1'b1;
			dma_chip_select_n_out <= 1'b1;
		end else if (clk_en_in) begin
			switch_read_strobe_n_out <=
				!(rd_active && io_addr_in == PORT_SWITCH_LAMP);
			lamp_latch_strobe_n_out <=
				!(wr_active && io_addr_in == PORT_SWITCH_LAMP);
			bank_strobe_n_out <=
				!(wr_active && io_addr_in == PORT_BANK);
			sync_test_strobe_n_out <=
				!(rd_active && io_addr_in == PORT_SYNC);
			dma_chip_select_n_out <= !dma_hit(io_addr_in);
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			lamp_out <= LAMP_RESET;
			bank_reg <= BANK_RESET;
		end else if (clk_en_in) begin
			if (wr_start && io_addr_in == PORT_SWITCH_LAMP) begin
				lamp_out <= io_data_in[LAMP_W-1:0];
			end
			if (wr_start && io_addr_in == PORT_BANK) begin
				bank_reg <= io_data_in[3:0];
			end
		end
	end

	// ----------
	// Bank switching
	// ----------
	// Outputs are registered, so the extended address lags the processor
	// address by one clock; memory timing must allow for that.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			extended_addr_bit15_out <= 1'b0;
			extended_addr_bit14_out <= 1'b0;
			program_memory_select_out <= 1'b0;
			map_protect_enable_out <= 1'b0;
		end else if (clk_en_in) begin
			map_protect_enable_out <= bank_reg[BANK_MAP_EN];
			if (cpu_mem_addr_in[CPU_UPPER_BIT]) begin
				extended_addr_bit15_out <= bank_reg[BANK_BLOCK_HI];
				extended_addr_bit14_out <= bank_reg[BANK_BLOCK_LO];
				program_memory_select_out <=
					!bank_reg[BANK_MEM_SEL];
			end else begin
				extended_addr_bit15_out <= 1'b0;
				extended_addr_bit14_out <= 1'b0;
				program_memory_select_out <= 1'b0;
			end
		end
	end

	// ----------
	// Read data
	// ----------
	assign mem_bus.cpu_idx = io_addr_in[2:0];

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			io_data_out <= 8'h00;
			io_data_oe_out <= 1'b0;
		end else if (clk_en_in) begin
			io_data_out <= 8'h00;
			io_data_oe_out <= 1'b0;
			if (rd_active) begin
				if (io_addr_in == PORT_SWITCH_LAMP) begin
					io_data_oe_out <= 1'b1;
					io_data_out[7:SWITCH_LSB] <= switch_sync_reg;
				end else if (io_addr_in == PORT_HSI_STATUS) begin
					io_data_oe_out <= 1'b1;
					io_data_out[STATUS_LAMP_BIT] <=
						lamp_out[SELF_TEST_LAMP_BIT];
				end else if (dma_general(io_addr_in)) begin
					io_data_oe_out <= 1'b1;
					io_data_out <= {4'h0, tc_status_reg};
				end else if (dma_channel(io_addr_in)) begin
					io_data_oe_out <= 1'b1;
					io_data_out <= byte_ptr_reg ?
						mem_bus.cpu_data[15:8] :
						mem_bus.cpu_data[7:0];
				end
			end
		end
	end

	// ----------
	// DMA programming: byte pointer, mode and status
	// ----------
	// The pointer flips when an access ends, so the byte chosen stays
	// steady for the whole read strobe.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			byte_ptr_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (wr_start && dma_general(io_addr_in)) begin
				byte_ptr_reg <= 1'b0;
			end else if ((rd_end || wr_end) &&
				dma_channel(acc_addr_reg)) begin
				byte_ptr_reg <= !byte_ptr_reg;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mode_reg <= MODE_RESET;
		end else if (clk_en_in) begin
			if (wr_start && dma_general(io_addr_in)) begin
				mode_reg <= io_data_in;
			end else if (dma_state_reg == DMA_OUT &&
				mem_bus.eng_data[COUNT_W-1:0] == COUNT_LAST &&
				mode_reg[MODE_TC_STOP]) begin
				mode_reg[chan_reg] <= 1'b0;
			end
		end
	end

	// Status bits are sticky; a new terminal count wins over the clear
	// that a status read performs.
	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_status
		assign tc_set[c] = dma_state_reg == DMA_OUT &&
			chan_reg == 2'(c) &&
			mem_bus.eng_data[COUNT_W-1:0] == COUNT_LAST;
		always_ff @(posedge clock_in) begin
			if (rst_in) begin
				tc_status_reg[c] <= TC_STATUS_RESET[c];
			end else if (clk_en_in) begin
				if (tc_set[c]) begin
					tc_status_reg[c] <= 1'b1;
				end else if (status_read_end) begin
					tc_status_reg[c] <= 1'b0;
				end
			end
		end
	end

	// ----------
	// Register store port control
	// ----------
	assign mem_bus.eng_idx = {chan_reg, dma_state_reg == DMA_CNT};

	always_comb begin
		mem_bus.wr_en = wr_start && dma_channel(io_addr_in);
		mem_bus.wr_idx = io_addr_in[2:0];
		mem_bus.wr_be = byte_ptr_reg ? 2'b10 : 2'b01;
		mem_bus.wr_data = {io_data_in, io_data_in};
		if (dma_state_reg == DMA_OUT) begin
			mem_bus.wr_en = 1'b1;
			mem_bus.wr_idx = {chan_reg, 1'b0};
			mem_bus.wr_be = 2'b11;
			mem_bus.wr_data = addr_reg + 16'h0001;
		end else if (dma_state_reg == DMA_WRC) begin
			mem_bus.wr_en = 1'b1;
			mem_bus.wr_idx = {chan_reg, 1'b1};
			mem_bus.wr_be = 2'b11;
			mem_bus.wr_data = {cnt_reg[15:COUNT_W],
				cnt_reg[COUNT_W-1:0] - 14'h0001};
		end
	end

	dma_reg_mem regs (
		.clock_in(clock_in),
		.clk_en_in(clk_en_in),
		.bus(mem_bus.store)
	);

	// ----------
	// DMA transfer engine
	// ----------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			dma_state_reg <= DMA_IDLE;
			chan_reg <= 2'h0;
			addr_reg <= 16'h0000;
			cnt_reg <= 16'h0000;
			hold_request_out <= 1'b0;
			dma_ack_out <= 4'h0;
			dma_cycle_out <= 1'b0;
			dma_addr_low_out <= 8'h00;
			dma_addr_high_out <= 8'h00;
			dma_cycle_type_out <= 2'h0;
			terminal_count_out <= 1'b0;
		end else if (clk_en_in) begin
			terminal_count_out <= 1'b0;
			case (dma_state_reg)
			DMA_IDLE: begin
				if (dma_req_all != 4'h0) begin
					hold_request_out <= 1'b1;
					dma_state_reg <= DMA_HOLD;
				end
			end
			DMA_HOLD: begin
				if (dma_req_all == 4'h0) begin
					hold_request_out <= 1'b0;
					dma_state_reg <= DMA_IDLE;
				end else if (hold_ack_in) begin
					chan_reg <= lowest(dma_req_all);
					dma_state_reg <= DMA_ADDR;
				end
			end
			DMA_ADDR: begin
				dma_state_reg <= DMA_CNT;
			end
			DMA_CNT: begin
				addr_reg <= mem_bus.eng_data;
				dma_addr_low_out <= mem_bus.eng_data[7:0];
				dma_addr_high_out <= mem_bus.eng_data[15:8];
				dma_ack_out <= 4'h1 << chan_reg;
				dma_cycle_out <= 1'b1;
				dma_state_reg <= DMA_OUT;
			end
			DMA_OUT: begin
				cnt_reg <= mem_bus.eng_data;
				dma_ack_out <= 4'h0;
				dma_cycle_out <= 1'b0;
				dma_cycle_type_out <= mem_bus.eng_data[15:COUNT_W];
				terminal_count_out <= mem_bus.eng_data[COUNT_W-1:0] ==
					COUNT_LAST;
				dma_state_reg <= DMA_WRC;
			end
			DMA_WRC: begin
				if (dma_req_all != 4'h0) begin
					chan_reg <= lowest(dma_req_all);
					dma_state_reg <= DMA_ADDR;
				end else begin
					hold_request_out <= 1'b0;
					dma_state_reg <= DMA_IDLE;
				end
			end
			default: begin
				hold_request_out <= 1'b0;
				dma_state_reg <= DMA_IDLE;
			end
			endcase
		end
	end
endmodule

// >>> design/sysio_pkg.sv
/*
 * Constants shared by the system I/O port decoder and its DMA register
 * store: port addresses, field positions, reset values, timing counts and
 * the DMA engine state type.
 * Assumes a single 40 MHz system clock.
 */
package sysio_pkg;

	// ------------------------------------------------------------------
	// Port addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] PORT_TIMER_RESET = 8'hec;
	localparam logic [7:0] PORT_SWITCH_LAMP = 8'hed;
	localparam logic [7:0] PORT_BANK = 8'hee;
	localparam logic [7:0] PORT_SYNC = 8'hef;
	localparam logic [7:0] PORT_HSI_STATUS = 8'he9;
	localparam logic [3:0] DMA_PORT_HIGH = 4'h9;
	localparam logic [7:0] DMA_CHAN0_ADDR_PORT = 8'h90;
	localparam int DMA_GROUP_BIT = 3;
	localparam logic [2:0] DMA_GENERAL_SEL = 3'h0;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLOCK_HZ = 40_000_000;
	localparam int unsigned TIMER_PERIOD_MS = 100;
	localparam int unsigned TIMER_PERIOD_CYCLES =
		CLOCK_HZ / 1000 * TIMER_PERIOD_MS;
	localparam int TIMER_CNT_W = 22;
	localparam logic [2:0] CPU_RESET_HOLD_CYCLES = 3'h4;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int TIMER_EN_BIT = 0;
	localparam int SWITCH_LSB = 2;
	localparam int LAMP_W = 6;
	localparam logic [5:0] LAMP_RESET = 6'h00;
	localparam int SELF_TEST_LAMP_BIT = 5;
	localparam int STATUS_LAMP_BIT = 6;
	localparam int BANK_BLOCK_LO = 0;
	localparam int BANK_BLOCK_HI = 1;
	localparam int BANK_MEM_SEL = 2;
	localparam int BANK_MAP_EN = 3;
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam int CPU_UPPER_BIT = 14;

	// ------------------------------------------------------------------
	// DMA controller
	// ------------------------------------------------------------------
	localparam int NUM_CHAN = 4;
	localparam int DMA_REG_COUNT = 8;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam int MODE_TC_STOP = 6;
	localparam logic [3:0] TC_STATUS_RESET = 4'h0;
	localparam int COUNT_W = 14;
	localparam logic [13:0] COUNT_LAST = 14'h0000;

	typedef enum {
		DMA_IDLE,
		DMA_HOLD,
		DMA_ADDR,
		DMA_CNT,
		DMA_OUT,
		DMA_WRC
	} dma_state_t;

endpackage

// >>> design/dma_mem_if.sv
/*
 * Bundle between the port decoder and the DMA register store: one write
 * port with byte enables and two read ports.
 * Assumes both ends run on the same system clock.
 */
interface dma_mem_if;
	logic wr_en;
	logic [2:0] wr_idx;
	logic [1:0] wr_be;
	logic [15:0] wr_data;
	logic [2:0] cpu_idx;
	logic [15:0] cpu_data;
	logic [2:0] eng_idx;
	logic [15:0] eng_data;

	modport user (
		output wr_en, wr_idx, wr_be, wr_data, cpu_idx, eng_idx,
		input cpu_data, eng_data
	);
	modport store (
		input wr_en, wr_idx, wr_be, wr_data, cpu_idx, eng_idx,
		output cpu_data, eng_data
	);
endinterface

// >>> design/dma_reg_mem.sv
/*
 * Eight 16-bit DMA channel registers (address and count per channel) with
 * byte-wide writes and two registered read ports.
 * Assumes the owner never writes the same word from two sources at once.
 */
module dma_reg_mem (
	input wire logic clock_in,
	input wire logic clk_en_in,
	dma_mem_if.store bus
);
	import sysio_pkg::*;

	logic [15:0] mem_reg [DMA_REG_COUNT];

	// ----------
	// Byte-lane writes
	// ----------
	// One process owns the array, so each word has a single driver.
	always_ff @(posedge clock_in) begin
		for (int b = 0; b < 2; b++) begin
			if (clk_en_in && bus.wr_en && bus.wr_be[b]) begin
				mem_reg[bus.wr_idx][b*8 +: 8] <= bus.wr_data[b*8 +: 8];
			end
		end
	end

	// ----------
	// Registered reads
	// ----------
	always_ff @(posedge clock_in) begin
		if (clk_en_in) begin
			bus.cpu_data <= mem_reg[bus.cpu_idx];
			bus.eng_data <= mem_reg[bus.eng_idx];
		end
	end
endmodule

// >>> dv/system_io_port_controller_assertions.sv
/*
 * Pin-level checks on the I/O port controller.
 * Assumes one clock with clk_en_in held high by the bench.
 */
module system_io_port_controller_assertions (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [7:0] io_addr_in,
	input wire logic [7:0] io_data_in,
	input wire logic io_read_strobe_n_in,
	input wire logic io_write_strobe_n_in,
	input wire logic [7:0] io_data_out,
	input wire logic io_data_oe_out,
	input wire logic [14:0] cpu_mem_addr_in,
	input wire logic timer_irq_ack_in,
	input wire logic cpu_reset_n_out,
	input wire logic timer_irq_out,
	input wire logic switch_read_strobe_n_out,
	input wire logic lamp_latch_strobe_n_out,
	input wire logic [5:0] lamp_out,
	input wire logic extended_addr_bit15_out,
	input wire logic extended_addr_bit14_out,
	input wire logic program_memory_select_out,
	input wire logic map_protect_enable_out,
	input wire logic sync_test_strobe_n_out,
	input wire logic dma_chip_select_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	sequence s_rd(logic [7:0] a);
		!io_read_strobe_n_in && io_addr_in == a;
	endsequence
	sequence s_reset_hold;
		!cpu_reset_n_out [*4] ##1 cpu_reset_n_out;
	endsequence
	property p_cpu_reset;
		$fell(cpu_reset_n_out) |->
			$past(!io_read_strobe_n_in && io_addr_in == 8'hec) ##0 s_reset_hold;
	endproperty
	a_cpu_reset: assert property (p_cpu_reset) else $error("reset pulse");
	property p_lamp;
		$fell(io_write_strobe_n_in) && io_addr_in == 8'hed |=>
			!lamp_latch_strobe_n_out && lamp_out == $past(io_data_in[5:0]);
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamp latch");
	property p_switch;
		s_rd(8'hed) |=> !switch_read_strobe_n_out && io_data_oe_out
			&& io_data_out[1:0] == 2'b00;
	endproperty
	a_switch: assert property (p_switch) else $error("switch read");
	property p_status_lamp;
		s_rd(8'he9) |=> io_data_oe_out
			&& io_data_out == {1'b0, $past(lamp_out[5]), 6'h00};
	endproperty
	a_status_lamp: assert property (p_status_lamp) else $error("e9 read");
	property p_sync;
		s_rd(8'hef) |=> !sync_test_strobe_n_out;
	endproperty
	a_sync: assert property (p_sync) else $error("sync strobe");
	property p_idle;
		io_read_strobe_n_in && io_write_strobe_n_in |=> !io_data_oe_out
			&& lamp_latch_strobe_n_out && sync_test_strobe_n_out;
	endproperty
	a_idle: assert property (p_idle) else $error("idle outputs");
	property p_low_half;
		!cpu_mem_addr_in[14] |=> !extended_addr_bit15_out
			&& !extended_addr_bit14_out && !program_memory_select_out;
	endproperty
	a_low_half: assert property (p_low_half) else $error("low half");
	property p_map;
		$changed(map_protect_enable_out) |->
			$past(!io_write_strobe_n_in && io_addr_in == 8'hee);
	endproperty
	a_map: assert property (p_map) else $error("map enable");
	property p_cs;
		1'b1 |=> dma_chip_select_n_out == ($past(io_addr_in[7:4]) != 4'h9);
	endproperty
	a_cs: assert property (p_cs) else $error("dma select");
	property p_irq_hold;
		timer_irq_out && !timer_irq_ack_in
			&& !(!io_write_strobe_n_in && io_addr_in == 8'hec) |=> timer_irq_out;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
endmodule

bind system_io_port_controller system_io_port_controller_assertions u_sva (
	.clock_in, .rst_in, .io_addr_in, .io_data_in, .io_read_strobe_n_in,
	.io_write_strobe_n_in, .io_data_out, .io_data_oe_out, .cpu_mem_addr_in,
	.timer_irq_ack_in, .cpu_reset_n_out, .timer_irq_out,
	.switch_read_strobe_n_out, .lamp_latch_strobe_n_out, .lamp_out,
	.extended_addr_bit15_out, .extended_addr_bit14_out,
	.program_memory_select_out, .map_protect_enable_out,
	.sync_test_strobe_n_out, .dma_chip_select_n_out
);

// >>> dv/cpu_bus_model.sv
/*
 * Processor side: I/O strobe cycles and hold acknowledge.
 * Assumes the controller's clock; the bench calls io and may set lag.
 */
module cpu_bus_model (
	input wire logic clock_in,
	input wire logic hold_request_in,
	input wire logic [7:0] rd_data_in,
	output logic [7:0] addr_out,
	output logic [7:0] data_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic hold_ack_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int lag = 0;
	logic [3:0] req_dly = 4'h0;
	initial begin
		addr_out = 8'h00;
		data_out = 8'h00;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		hold_ack_out = 1'b0;
	end
	// Acknowledge only a standing request, after lag extra cycles.
	always @(posedge clock_in) begin
		req_dly <= {req_dly[2:0], hold_request_in};
		hold_ack_out <= hold_request_in && req_dly[lag];
	end
	// Strobe held over four edges so channel reads have settled.
	task automatic io(input logic wr, input logic [7:0] a, d,
		output logic [7:0] q);
		@(posedge clock_in);
		addr_out <= a;
		data_out <= d;
		wr_n_out <= !wr;
		rd_n_out <= wr;
		repeat (3) @(posedge clock_in);
		#1 q = rd_data_in;
		@(posedge clock_in);
		wr_n_out <= 1'b1;
		rd_n_out <= 1'b1;
		// A released bus must not keep showing the last byte.
		data_out <= ~d;
		#1;
	endtask
endmodule

// >>> dv/system_io_port_controller_tb.sv
/*
 * Self-checking bench for the I/O port controller.
 * Assumes the processor model drives the I/O bus and hold acknowledge.
 */
module system_io_port_controller_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned PER = 20;
	typedef struct packed {logic a14; logic [7:0] d; logic [3:0] e;} row_t;
	// Expected {bit15, bit14, program select, map enable} per bank write.
	row_t rows[8] = '{'{1, 8'h05, 4'h4}, '{1, 8'h06, 4'h8},
		'{1, 8'h0f, 4'hd}, '{1, 8'h00, 4'h2}, '{1, 8'h09, 4'h7},
		'{1, 8'h0a, 4'hb}, '{1, 8'h03, 4'he}, '{0, 8'h0f, 4'h1}};
	logic clock_in, rst_in, clk_en_in, io_read_strobe_n_in;
	logic io_write_strobe_n_in, io_data_oe_out, timer_irq_ack_in;
	logic [7:0] io_addr_in, io_data_in, io_data_out, q;
	logic [7:0] dma_addr_low_out, dma_addr_high_out;
	logic [14:0] cpu_mem_addr_in;
	logic [5:0] diag_switch_in, lamp_out;
	logic [2:0] dma_req_in;
	logic [3:0] dma_ack_out;
	logic [1:0] dma_cycle_type_out;
	logic hold_ack_in, cpu_reset_n_out, timer_irq_out, bank_strobe_n_out;
	logic switch_read_strobe_n_out, lamp_latch_strobe_n_out;
	logic extended_addr_bit15_out, extended_addr_bit14_out;
	logic program_memory_select_out, map_protect_enable_out;
	logic sync_test_strobe_n_out, dma_chip_select_n_out, hold_request_out;
	logic dma_cycle_out, terminal_count_out;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;

	system_io_port_controller #(.TIMER_PERIOD_P(PER)) u_system_io_port_controller (
		.clock_in, .rst_in, .clk_en_in, .io_addr_in, .io_data_in,
		.io_read_strobe_n_in, .io_write_strobe_n_in, .io_data_out,
		.io_data_oe_out, .cpu_mem_addr_in, .diag_switch_in, .timer_irq_ack_in,
		.dma_req_in, .hold_ack_in, .cpu_reset_n_out, .timer_irq_out,
		.switch_read_strobe_n_out, .lamp_latch_strobe_n_out, .lamp_out,
		.bank_strobe_n_out, .extended_addr_bit15_out, .extended_addr_bit14_out,
		.program_memory_select_out, .map_protect_enable_out,
		.sync_test_strobe_n_out, .dma_chip_select_n_out, .hold_request_out,
		.dma_ack_out, .dma_cycle_out, .dma_addr_low_out, .dma_addr_high_out,
		.dma_cycle_type_out, .terminal_count_out);
	cpu_bus_model u_cpu_bus_model (.clock_in(clock_in),
		.hold_request_in(hold_request_out), .rd_data_in(io_data_out),
		.addr_out(io_addr_in), .data_out(io_data_in),
		.rd_n_out(io_read_strobe_n_in), .wr_n_out(io_write_strobe_n_in),
		.hold_ack_out(hold_ack_in));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic chk(input logic [15:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %0t value %h not %h", $time, got, exp);
		end
	endtask
	task automatic io(input logic wr, input logic [7:0] a, d);
		u_cpu_bus_model.io(wr, a, d, q);
	endtask
	task automatic wait_dma;
		int n;
		n = 0;
		do begin
			@(posedge clock_in);
			#1 n++;
		end while (dma_cycle_out !== 1'b1 && n < 64);
	endtask
	task automatic give_verdict;
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end
	// Whole run is well under a thousand cycles.
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		{rst_in, clk_en_in, timer_irq_ack_in, dma_req_in} = 6'h30;
		cpu_mem_addr_in = 15'h0000;
		diag_switch_in = 6'h2d;
		repeat (8) @(posedge clock_in);
		rst_in <= 1'b0;
		@(posedge clock_in);
		#1 chk({lamp_out, map_protect_enable_out, cpu_reset_n_out}, 16'h1);
		foreach (rows[i]) begin
			cpu_mem_addr_in <= {rows[i].a14, 14'h0000};
			io(1, 8'hee, rows[i].d);
			chk({extended_addr_bit15_out, extended_addr_bit14_out,
				program_memory_select_out, map_protect_enable_out}, rows[i].e);
		end
		io(1, 8'hed, 8'h2a);
		chk(lamp_out, 16'h2a);
		io(0, 8'he9, 8'h00);
		chk(q, 16'h40);
		io(0, 8'hed, 8'h00);
		chk(q, 16'hb4);
		io(0, 8'hef, 8'h00);
		io(0, 8'hec, 8'h00);
		chk(cpu_reset_n_out, 16'h0);
		io(1, 8'hec, 8'h01);
		repeat (PER - 4) @(posedge clock_in);
		#1 chk(timer_irq_out, 16'h0);
		@(posedge clock_in);
		#1 chk(timer_irq_out, 16'h1);
		timer_irq_ack_in <= 1'b1;
		@(posedge clock_in);
		timer_irq_ack_in <= 1'b0;
		#1 chk(timer_irq_out, 16'h0);
		repeat (PER) @(posedge clock_in);
		#1 chk(timer_irq_out, 16'h1);
		io(1, 8'hec, 8'h00);
		repeat (PER + 2) @(posedge clock_in);
		#1 chk(timer_irq_out, 16'h0);
		io(1, 8'h90, 8'hff);
		io(1, 8'h98, 8'h00);
		io(1, 8'h90, 8'h34);
		io(1, 8'h90, 8'h12);
		io(1, 8'h91, 8'h01);
		io(1, 8'h91, 8'h40);
		io(0, 8'h90, 8'h00);
		chk(q, 16'h34);
		io(0, 8'h90, 8'h00);
		chk(q, 16'h12);
		io(0, 8'h91, 8'h00);
		chk(q, 16'h01);
		io(1, 8'h9f, 8'h00);
		io(1, 8'h98, 8'h01);
		u_cpu_bus_model.lag = 2;
		@(posedge clock_in);
		dma_req_in <= 3'b001;
		wait_dma();
		chk({dma_addr_high_out, dma_addr_low_out}, 16'h1234);
		chk(dma_ack_out, 16'h1);
		wait_dma();
		chk({dma_addr_high_out, dma_addr_low_out}, 16'h1235);
		@(posedge clock_in);
		dma_req_in <= 3'b000;
		#1 chk({terminal_count_out, dma_cycle_type_out}, 16'h5);
		repeat (8) @(posedge clock_in);
		io(0, 8'h98, 8'h00);
		chk(q, 16'h01);
		give_verdict();
	end
endmodule
